// ==== hdl/ptd_pkg.sv ====
package ptd_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  localparam int unsigned MS_CW = 17;
  localparam int unsigned LEN_W = 13;
  localparam logic [LEN_W-1:0] TOL_MS = 13'h14;
  localparam logic [LEN_W-1:0] DEB_MS = 13'h1e;
  localparam logic [LEN_W-1:0] LASER_OFF_MS = 13'hc8;
  localparam logic [LEN_W-1:0] LASER_ON_MS = 13'h12c;
  localparam logic [LEN_W-1:0] TEACH_FIRST_MS = 13'h190;
  localparam logic [LEN_W-1:0] STEP_MS = 13'h64;
  localparam logic [LEN_W-1:0] CONF_OFF_MS = 13'h8fc;
  localparam logic [LEN_W-1:0] CONF_ON_MS = 13'h960;
  localparam logic [LEN_W-1:0] LONG_OFF_MS = 13'h1388;
  localparam int unsigned NUM_TEACH = 24;
  localparam logic [4:0] CONF_OFF_IDX = 5'h13;
  localparam logic [4:0] CONF_ON_IDX = 5'h14;
  localparam logic [LEN_W-1:0] EXEC_MAX_MS = 13'h3e8;
  localparam logic [LEN_W-1:0] CONF_INV_MS = 13'h64;
  localparam logic [LEN_W-1:0] CONF_OK_MS = 13'h64;
  localparam logic [LEN_W-1:0] CONF_ERR_MS = 13'h12c;
  localparam logic [LEN_W-1:0] CONF_END_MS = 13'h1f4;
  localparam logic [2:0] FN_TEACH = 3'h0;
  localparam logic [2:0] FN_HOLD = 3'h1;
  localparam logic [2:0] FN_OFFSET = 3'h2;
  localparam logic [2:0] FN_LASER = 3'h3;
  localparam logic [2:0] FN_OFF = 3'h4;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_CONF} ptd_state_t;
endpackage

// ==== hdl/ptd_decoder.sv ====
// How it works
// - teach mode measures asserted input length
// - accept pulse within 20 ms of nominal
// - laser 200/300, confirm 2300/2400, long off
// - 400..1000 ms teach first output
// - 1100..1700 ms teach second output
// - 1800..2200 ms analog teach points, centering
// - 2500..2800 ms signal warning teaches
// - 2900 ms teaches zero point
// - five input functions, teach default
// - debounce needs 30 ms stable level
// - debounce delays both edges equally, so width is kept
// - polarity selectable, high default
// - confirmation on first output, default off
// - first output frozen during teach
// - teach completes within one second
// - confirmation starts with 100 ms inversion
// - result pulse 100 ok, 300 fail
// - confirmation ends after 500 ms
// - laser-off function follows asserted input
`timescale 1ns/1ps
`default_nettype none
module ptd_decoder
  import ptd_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_config_input,
  input wire logic [2:0] i_in_function,
  input wire logic i_debounce_en,
  input wire logic i_active_low,
  input wire logic i_switch_level,
  input wire logic i_teach_done,
  input wire logic i_teach_ok,
  output logic o_first_switch_output,
  output logic o_laser_on,
  output logic o_confirm_en,
  output logic o_teach_req,
  output logic [4:0] o_teach_code,
  output logic o_busy
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    // time base
    logic [MS_CW-1:0] pre;
    logic tick;

    // input filter and length
    logic deb_lvl;
    logic [LEN_W-1:0] deb_cnt;
    logic act_q;
    logic [LEN_W-1:0] len;

    // settings
    logic laser_set;
    logic laser;
    logic conf_en;

    // teach request
    logic req;
    logic [4:0] code;

    // sequencer and first output
    ptd_state_t st;
    logic [LEN_W-1:0] tcnt;
    logic ok;
    logic held;
    logic q1;

    // busy flag
    logic busy;
  } ptd_regs_t;

  ptd_regs_t r_q, r_d;

  ////////////////////////////////////////////////////////////////////////////
  // window test done one bit wider so a saturated length cannot wrap
  function automatic logic in_win(input logic [LEN_W-1:0] len, input logic [LEN_W-1:0] nom);
    logic [LEN_W:0] len_x;
    logic [LEN_W:0] nom_x;
    logic [LEN_W:0] tol_x;
    len_x = {1'b0, len};
    nom_x = {1'b0, nom};
    tol_x = {1'b0, TOL_MS};
    in_win = (len_x + tol_x >= nom_x) && (len_x <= nom_x + tol_x);
  endfunction

  logic act_raw;
  logic lvl;
  logic [LEN_W-1:0] meas;
  logic hit;
  logic [4:0] hit_idx;
  logic st_idle;
  logic pre_wrap;
  logic rise_evt;
  logic fall_evt;
  logic teach_fn;
  logic is_long;
  logic is_off;
  logic is_on;
  logic exec_tmo;
  logic [LEN_W-1:0] conf_res_end;
  logic conf_inv_ph;
  logic conf_res_ph;
  logic conf_done;

  ////////////////////////////////////////////////////////////////////////////
  // input conditioning
  assign act_raw = i_config_input ^ i_active_low;
  // filtered level only when debounce is on
  assign lvl = i_debounce_en ? r_q.deb_lvl : act_raw;
  assign rise_evt = lvl && !r_q.act_q;
  assign fall_evt = !lvl && r_q.act_q;
  assign teach_fn = (i_in_function == FN_TEACH);
  assign st_idle = (r_q.st == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // millisecond time base
  assign pre_wrap = (r_q.pre == MS_CW'(MS_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // both edges delayed equally by filter, so width is kept
  assign meas = r_q.len;
  assign is_long = (meas > LONG_OFF_MS);
  assign is_off = in_win(meas, LASER_OFF_MS);
  assign is_on = in_win(meas, LASER_ON_MS);

  ////////////////////////////////////////////////////////////////////////////
  // one window comparator per command length, 400 ms upward
  localparam int unsigned NUM_WIN = NUM_TEACH + 2;
  localparam logic [LEN_W-1:0] LEN_SAT = {LEN_W{1'b1}};
  logic [NUM_WIN-1:0] win_hit;
  for (genvar g = 0; g < NUM_WIN; g++) begin : g_win
    localparam logic [LEN_W-1:0] WIN_NOM = LEN_W'(TEACH_FIRST_MS + LEN_W'(g) * STEP_MS);
    assign win_hit[g] = in_win(meas, WIN_NOM);
  end

  ////////////////////////////////////////////////////////////////////////////
  // execution and confirmation timing
  assign exec_tmo = r_q.tick && (r_q.tcnt >= EXEC_MAX_MS - 1'b1);
  assign conf_res_end = CONF_INV_MS + (r_q.ok ? CONF_OK_MS : CONF_ERR_MS);
  assign conf_inv_ph = (r_q.tcnt < CONF_INV_MS);
  assign conf_res_ph = (r_q.tcnt < conf_res_end);
  assign conf_done = (r_q.tcnt >= CONF_END_MS);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_d = r_q;
    hit = 1'b0;
    hit_idx = 5'h0;
    r_d.req = 1'b0;
    r_d.tick = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // millisecond prescaler
    if (pre_wrap) begin
      r_d.pre = '0;
      r_d.tick = 1'b1;
    end else begin
      r_d.pre = r_q.pre + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // debounce filter
    if (act_raw == r_q.deb_lvl) begin
      r_d.deb_cnt = '0;
    end else if (r_q.tick) begin
      if (r_q.deb_cnt >= DEB_MS - 1'b1) begin
        r_d.deb_lvl = act_raw;
        r_d.deb_cnt = '0;
      end else begin
        r_d.deb_cnt = r_q.deb_cnt + 1'b1;
      end
    end
    r_d.act_q = lvl;

    ////////////////////////////////////////////////////////////////////////
    // pulse length in whole milliseconds, saturating
    if (rise_evt) begin
      r_d.len = '0;
    end else if (lvl && r_q.tick && r_q.len != LEN_SAT) begin
      r_d.len = r_q.len + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // command decode on the inactive-going edge
    if (fall_evt && teach_fn) begin
      if (is_long) begin
        r_d.laser_set = 1'b0;
      end else if (is_off) begin
        r_d.laser_set = 1'b0;
      end else if (is_on) begin
        r_d.laser_set = 1'b1;
      end else begin
        // lowest matching window wins
        for (int k = NUM_WIN - 1; k >= 0; k--) begin
          if (win_hit[k]) begin
            hit = 1'b1;
            hit_idx = 5'(k);
          end
        end
        if (hit && hit_idx == CONF_OFF_IDX) begin
          r_d.conf_en = 1'b0;
        end else if (hit && hit_idx == CONF_ON_IDX) begin
          r_d.conf_en = 1'b1;
        end else if (hit && st_idle) begin
          // teach codes handed to the teach engine:
          // 0..6 first output, 7..13 second output
          // 14..17 analog points, 18 analog centering
          // 21..24 signal warning teaches, 25 zero point
          r_d.req = 1'b1;
          r_d.code = hit_idx;
          r_d.st = ST_EXEC;
          r_d.tcnt = '0;
          r_d.held = i_switch_level;
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // laser control
    if (i_in_function == FN_LASER) begin
      r_d.laser = !lvl;
    end else begin
      r_d.laser = r_q.laser_set;
    end

    ////////////////////////////////////////////////////////////////////////
    // teach sequencer and first output
    case (r_q.st)
      ST_IDLE: begin
        // output follows the switching logic
        r_d.q1 = i_switch_level;
      end

      ST_EXEC: begin
        // hold output, wait for the teach engine
        r_d.q1 = r_q.held;
        if (r_q.tick) begin
          r_d.tcnt = r_q.tcnt + 1'b1;
        end
        if (i_teach_done || exec_tmo) begin
          r_d.ok = i_teach_done && i_teach_ok;
          r_d.tcnt = '0;
          r_d.st = r_q.conf_en ? ST_CONF : ST_IDLE;
        end
      end

      ST_CONF: begin
        // invert, report, invert again, then release
        if (r_q.tick) begin
          r_d.tcnt = r_q.tcnt + 1'b1;
        end
        if (conf_inv_ph) begin
          r_d.q1 = !r_q.held;
        end else if (conf_res_ph) begin
          r_d.q1 = r_q.held;
        end else begin
          r_d.q1 = !r_q.held;
        end
        if (conf_done) begin
          r_d.st = ST_IDLE;
          r_d.q1 = i_switch_level;
        end
      end

      default: begin
        r_d.st = ST_IDLE;
      end
    endcase

    // busy from the next state so it rises with the request
    r_d.busy = (r_d.st != ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, frozen while clock enable is low
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_q <= '0;
      r_q.laser_set <= 1'b1;
      r_q.laser <= 1'b1;
      r_q.st <= ST_IDLE;
    end else if (i_ce) begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign o_first_switch_output = r_q.q1;
  assign o_laser_on = r_q.laser;
  assign o_confirm_en = r_q.conf_en;
  assign o_teach_req = r_q.req;
  assign o_teach_code = r_q.code;
  assign o_busy = r_q.busy;

endmodule
`default_nettype wire

// ==== bench/ptd_decoder_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptd_decoder_properties (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic o_first_switch_output,
  input wire logic o_confirm_en,
  input wire logic o_teach_req,
  input wire logic [4:0] o_teach_code,
  input wire logic o_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_conf;
    o_teach_req && o_confirm_en;
  endsequence
  req_pulse_a: assert property (o_teach_req |=> !o_teach_req) else $error("req long");
  req_idle_a: assert property (o_teach_req |-> !$past(o_busy)) else $error("req busy");
  busy_cause_a: assert property ($rose(o_busy) |-> o_teach_req) else $error("busy cause");
  req_busy_a: assert property (o_teach_req |=> o_busy) else $error("no exec");
  code_held_a: assert property (!o_teach_req |-> $stable(o_teach_code)) else $error("code moved");
  code_range_a: assert property (o_teach_req |-> o_teach_code <= 5'h19) else $error("bad code");
  q1_frozen_a: assert property (o_busy && $past(o_busy) && !o_confirm_en |->
    $stable(o_first_switch_output)) else $error("q1 moved");
  conf_busy_a: assert property (s_conf |-> o_busy [*8]) else $error("conf short");
endmodule
bind ptd_decoder ptd_decoder_properties u_prop (.i_core_clk, .i_rst_n, .o_first_switch_output,
  .o_confirm_en, .o_teach_req, .o_teach_code, .o_busy);
`default_nettype wire

// ==== bench/ptd_pulse_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptd_pulse_src (
  input wire logic i_core_clk,
  input wire logic i_active_low,
  output logic o_level
);
  logic act = 1'b0;
  assign o_level = act ^ i_active_low;
  task automatic send(input int cyc);
    @(posedge i_core_clk);
    act <= 1'b1;
    repeat (cyc) @(posedge i_core_clk);
    act <= 1'b0;
  endtask
  task automatic hold(input logic v);
    @(posedge i_core_clk);
    act <= v;
  endtask
endmodule
`default_nettype wire

// ==== bench/test_ptd_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_ptd_decoder;
  localparam int MC = 2;
  logic clk = 0, rst_n = 0, deb = 1, alow = 0, done = 0, ok = 0;
  logic sw = 0, auto_done = 1;
  logic [2:0] fn = 3'h0;
  logic cfg, q1, laser, cen, req, busy;
  logic [4:0] code;
  logic [4:0] lastc = 5'h1f;
  int failures = 0, num_checks = 0;
  int nreq = 0, n = 0;
  int tms[12] = '{200, 300, 5600, 418, 982, 1100, 1700, 1800, 2200, 2510, 2900, 1050};
  logic [4:0] tcd[12] = '{5'h1f, 5'h1f, 5'h1f, 5'h0, 5'h6, 5'h7, 5'hd, 5'he, 5'h12, 5'h15, 5'h19, 5'h1f};
  ptd_pulse_src src (.i_core_clk(clk), .i_active_low(alow), .o_level(cfg));
  ptd_decoder #(.MS_CYCLES(MC)) uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_config_input(cfg),
    .i_in_function(fn), .i_debounce_en(deb), .i_active_low(alow), .i_switch_level(sw), .i_teach_done(done),
    .i_teach_ok(ok), .o_first_switch_output(q1), .o_laser_on(laser), .o_confirm_en(cen), .o_teach_req(req),
    .o_teach_code(code), .o_busy(busy));
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    done <= auto_done && req === 1'b1;
    if (req === 1'b1) begin
      lastc <= code;
      nreq <= nreq + 1;
    end
  end
  task automatic check(input string what, input logic [4:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input int ms, input logic [4:0] exp);
    int n0;
    n0 = nreq;
    src.send(ms * MC);
    repeat (45 * MC) @(posedge clk);
    check("code", exp, (nreq == n0) ? 5'h1f : lastc);
  endtask
  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    check("confirm", 5'h0, 5'(cen));
    foreach (tms[i]) begin
      cmd(tms[i], tcd[i]);
      if (i < 3) check("laser", 5'(i == 1), 5'(laser));
    end
    cmd(2400, 5'h1f);
    for (int k = 0; k < 2; k++) begin
      ok <= k[0];
      src.send(400 * MC);
      n = 0;
      while (n < 50 * MC && req !== 1'b1) begin
        @(posedge clk);
        n++;
      end
      check("debounce", 5'h1, 5'(n >= 28 * MC && n <= 34 * MC));
      repeat (50 * MC) @(posedge clk);
      check("q1", 5'h1, 5'(q1));
      repeat (200 * MC) @(posedge clk);
      check("q1", 5'(k), 5'(q1));
      repeat (350 * MC) @(posedge clk);
      check("q1", 5'h0, 5'(q1));
    end
    cmd(2300, 5'h1f);
    check("confirm", 5'h0, 5'(cen));
    sw <= 1'b1;
    auto_done <= 1'b0;
    src.send(400 * MC);
    n = 0;
    while (n < 50 * MC && req !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    sw <= 1'b0;
    repeat (100 * MC) @(posedge clk);
    check("held q1", 5'h1, 5'(q1));
    repeat (800 * MC) @(posedge clk);
    check("busy", 5'h1, 5'(busy));
    repeat (150 * MC) @(posedge clk);
    check("busy", 5'h0, 5'(busy));
    check("q1", 5'h0, 5'(q1));
    auto_done <= 1'b1;
    deb <= 0;
    alow <= 1;
    cmd(700, 5'h3);
    fn <= 3'h3;
    src.hold(1'b1);
    repeat (4) @(posedge clk);
    check("laser", 5'h0, 5'(laser));
    src.hold(1'b0);
    repeat (4) @(posedge clk);
    check("laser", 5'h1, 5'(laser));
    fn <= 3'h1;
    cmd(400, 5'h1f);
    report_and_stop();
  end
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
